// ==== logic/tcp_timer_channels.v ====
// channel enable/polarity, counter and prescaler with ahb-lite slave
`timescale 1ns/1ns
`include "tcp_consts.vh"

module tcp_timer_channels (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // links to the rest of the timer (same clock)
    input  wire [7:0]  channelDirection,
    input  wire [1:0]  lockLevel,
    input  wire        commutationEvent,
    input  wire [3:0]  compareRef,
    input  wire [2:0]  compareRefComplement,
    // input channel pins (asynchronous)
    input  wire [3:0]  channelInputPin,
    // channel output pins
    output reg  [3:0]  compareOut,
    output reg  [2:0]  compareOutComplement,
    // capture and counter outputs
    output reg  [3:0]  captureStrobe,
    output reg  [15:0] capturedValue,
    output wire        counterTickClock
);

    reg  [15:0] channelEnablePolarity;
    reg  [15:0] counterValue;
    reg  [15:0] dividerValue;
    reg  [15:0] control;
    reg  [2:0]  compPolarityActive;
    reg  [15:0] dividerCount;
    reg         counterTick;
    reg  [3:0]  pinSync1;
    reg  [3:0]  pinSync2;
    reg  [3:0]  pinLast;
    reg         phaseWrite;
    reg  [11:0] phaseAddr;
    reg  [31:0] readData;
    wire        addrTaken;
    wire        writeEnable;
    wire        compWriteAllowed;
    wire [15:0] enableWriteValue;
    wire [15:0] dividerNext;
    wire [3:0]  isInput;
    wire [3:0]  risingEdge;
    wire [3:0]  fallingEdge;
    reg  [3:0]  edgeHit;
    reg  [3:0]  next_capture;
    reg  [3:0]  next_compareOut;
    reg  [2:0]  next_compareOutComplement;
    wire [11:0] phaseWordAddr;
    wire        phaseHitEnable;
    wire        phaseHitCounter;
    wire        phaseHitDivider;
    wire        phaseHitControl;
    wire [15:0] enableNow;
    wire [15:0] counterNow;
    wire [15:0] dividerNow;
    wire [15:0] controlNow;
    wire [3:0]  chEnable;
    wire [3:0]  chPolarity;
    wire [2:0]  chCompEnable;
    wire [2:0]  chCompPolarity;
    wire [3:0]  edgeCompPolarity;
    integer     chLoad;
    integer     chEdge;
    integer     chCap;
    integer     chOut;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = readData;
    assign addrTaken = hsel & hready & (htrans == `TCP_HTRANS_NONSEQ);
    assign writeEnable = phaseWrite;

    // data-phase address decode; a read right behind a write is given
    // the word that lands at the same edge instead of the stale one
    assign phaseWordAddr   = {phaseAddr[11:2], 2'b00};
    assign phaseHitEnable  = writeEnable &
                             (phaseWordAddr == `TCP_ADDR_ENABLE);
    assign phaseHitCounter = writeEnable &
                             (phaseWordAddr == `TCP_ADDR_COUNTER);
    assign phaseHitDivider = writeEnable &
                             (phaseWordAddr == `TCP_ADDR_DIVIDER);
    assign phaseHitControl = writeEnable &
                             (phaseWordAddr == `TCP_ADDR_CONTROL);
    assign enableNow  = phaseHitEnable ? enableWriteValue
                                       : channelEnablePolarity;
    assign counterNow = phaseHitCounter ? hwdata[15:0] : counterValue;
    assign dividerNow = phaseHitDivider ? hwdata[15:0] : dividerValue;
    assign controlNow = phaseHitControl ? (hwdata[15:0] & `TCP_CTL_MASK)
                                        : control;

    // address phase capture
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseWrite <= 1'b0;
            phaseAddr  <= 12'h000;
        end else if (hready) begin
            phaseWrite <= addrTaken & hwrite;
            phaseAddr  <= haddr;
        end
    end

    // read data registered at the address phase, unmapped read zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= 32'h0000_0000;
        end else if (addrTaken & !hwrite) begin
            case ({haddr[11:2], 2'b00})
                `TCP_ADDR_ENABLE:
                    readData <= {16'h0000, enableNow};
                `TCP_ADDR_COUNTER:
                    readData <= {16'h0000, counterNow};
                `TCP_ADDR_DIVIDER:
                    readData <= {16'h0000, dividerNow};
                `TCP_ADDR_CONTROL:
                    readData <= {16'h0000, controlNow};
                default:
                    readData <= 32'h0000_0000;
            endcase
        end
    end

    assign compWriteAllowed = (lockLevel < 2'd2);
    // keep complementary polarity bits at lock level two or three, clear reserved bits
    assign enableWriteValue = {
        2'b00,
        hwdata[13:12],
        compWriteAllowed ? hwdata[11] : channelEnablePolarity[11],
        hwdata[10:8],
        compWriteAllowed ? hwdata[7] : channelEnablePolarity[7],
        hwdata[6:4],
        compWriteAllowed ? hwdata[3] : channelEnablePolarity[3],
        hwdata[2:0]
    };

    // register file
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channelEnablePolarity <= `TCP_RST_ENABLE;
            dividerValue          <= `TCP_RST_DIVIDER;
            control               <= `TCP_RST_CONTROL;
        end else if (writeEnable) begin
            case ({phaseAddr[11:2], 2'b00})
                `TCP_ADDR_ENABLE:
                    channelEnablePolarity <= enableWriteValue;
                `TCP_ADDR_DIVIDER:
                    dividerValue <= hwdata[15:0];
                `TCP_ADDR_CONTROL:
                    control <= hwdata[15:0] & `TCP_CTL_MASK;
                default: ;
            endcase
        end
    end

    // active complementary polarity, preloaded until commutation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compPolarityActive <= 3'b000;
        end else begin
            for (chLoad = 0; chLoad < 3; chLoad = chLoad + 1) begin
                if (!control[`TCP_CTL_PRELOAD] || commutationEvent) begin
                    compPolarityActive[chLoad] <=
                        chCompPolarity[chLoad];
                end
            end
        end
    end

    // prescaler: one tick every divider plus one clocks
    assign dividerNext = dividerCount + 16'h0001;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dividerCount <= 16'h0000;
            counterTick  <= 1'b0;
        end else if (control[`TCP_CTL_COUNT_EN]) begin
            if (dividerCount >= dividerValue) begin
                dividerCount <= 16'h0000;
                counterTick  <= 1'b1;
            end else begin
                dividerCount <= dividerNext;
                counterTick  <= 1'b0;
            end
        end else begin
            dividerCount <= 16'h0000;
            counterTick  <= 1'b0;
        end
    end
    assign counterTickClock = counterTick;

    // counter; software write wins over a tick
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counterValue <= `TCP_RST_COUNTER;
        end else if (phaseHitCounter) begin
            counterValue <= hwdata[15:0];
        end else if (counterTick) begin
            counterValue <= counterValue + 16'h0001;
        end
    end

    // input pin synchroniser and edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= 4'h0;
            pinSync2 <= 4'h0;
            pinLast  <= 4'h0;
        end else begin
            pinSync1 <= channelInputPin;
            pinSync2 <= pinSync1;
            pinLast  <= pinSync2;
        end
    end
    assign risingEdge  = pinSync2 & ~pinLast;
    assign fallingEdge = ~pinSync2 & pinLast;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gDir
            assign isInput[g] = |channelDirection[2*g+1:2*g];
        end
        // per-channel fields of the enable/polarity register
        for (g = 0; g < 4; g = g + 1) begin : gField
            assign chEnable[g]   = channelEnablePolarity[4*g + `TCP_BIT_EN];
            assign chPolarity[g] = channelEnablePolarity[4*g + `TCP_BIT_POL];
        end
        for (g = 0; g < 3; g = g + 1) begin : gCompField
            assign chCompEnable[g]   =
                channelEnablePolarity[4*g + `TCP_BIT_CEN];
            assign chCompPolarity[g] =
                channelEnablePolarity[4*g + `TCP_BIT_CPOL];
        end
    endgenerate

    // channel four has no complementary pair bit; decode it as zero
    assign edgeCompPolarity = {1'b0, chCompPolarity};

    // edge select from polarity pair; channel four has no pair bit
    always @* begin
        edgeHit = 4'h0;
        for (chEdge = 0; chEdge < 4; chEdge = chEdge + 1) begin
            case ({edgeCompPolarity[chEdge], chPolarity[chEdge]})
                2'b00: edgeHit[chEdge] = risingEdge[chEdge];
                2'b01: edgeHit[chEdge] = fallingEdge[chEdge];
                2'b11: edgeHit[chEdge] = risingEdge[chEdge] |
                                         fallingEdge[chEdge];
                default: edgeHit[chEdge] = 1'b0;
            endcase
        end
    end

    always @* begin
        next_capture = 4'h0;
        for (chCap = 0; chCap < 4; chCap = chCap + 1) begin
            next_capture[chCap] = isInput[chCap] & edgeHit[chCap] &
                                  chEnable[chCap];
        end
    end

    // capture strobes with counter snapshot
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            captureStrobe <= 4'h0;
            capturedValue <= 16'h0000;
        end else begin
            captureStrobe <= next_capture;
            if (|next_capture) begin
                capturedValue <= counterValue;
            end
        end
    end

    // next output levels: polarity applied, inactive level when disabled
    always @* begin
        next_compareOut           = 4'h0;
        next_compareOutComplement = 3'b000;
        for (chOut = 0; chOut < 4; chOut = chOut + 1) begin
            if (!isInput[chOut] && chEnable[chOut]) begin
                next_compareOut[chOut] =
                    compareRef[chOut] ^ chPolarity[chOut];
            end else begin
                next_compareOut[chOut] = chPolarity[chOut];
            end
        end
        for (chOut = 0; chOut < 3; chOut = chOut + 1) begin
            if (!isInput[chOut] && chCompEnable[chOut]) begin
                next_compareOutComplement[chOut] =
                    compareRefComplement[chOut] ^
                    compPolarityActive[chOut];
            end else begin
                next_compareOutComplement[chOut] =
                    compPolarityActive[chOut];
            end
        end
    end

    // output pins registered so that no glitch reaches them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareOut           <= 4'h0;
            compareOutComplement <= 3'b000;
        end else begin
            compareOut           <= next_compareOut;
            compareOutComplement <= next_compareOutComplement;
        end
    end

endmodule // tcp_timer_channels

// ==== logic/tcp_consts.vh ====
// constants for the timer channel enable, counter and prescaler block
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH
`define TCP_ADDR_ENABLE      12'h020
`define TCP_ADDR_COUNTER     12'h024
`define TCP_ADDR_DIVIDER     12'h028
`define TCP_ADDR_CONTROL     12'h02C
`define TCP_RST_ENABLE       16'h0000
`define TCP_RST_COUNTER      16'h0000
`define TCP_RST_DIVIDER      16'h0000
`define TCP_RST_CONTROL      16'h0000
`define TCP_ENABLE_MASK      16'h3FFF
`define TCP_BIT_EN           0
`define TCP_BIT_POL          1
`define TCP_BIT_CEN          2
`define TCP_BIT_CPOL         3
`define TCP_CTL_PRELOAD      0
`define TCP_CTL_COUNT_EN     1
`define TCP_CTL_MASK         16'h0003
`define TCP_HTRANS_NONSEQ    2'b10
`endif

// ==== testbench/tcp_timer_channels_asserts.sv ====
// assertions on the timer channel block's ports
`timescale 1ns/1ns
`include "tcp_consts.vh"
module tcp_timer_channels_asserts (
    // clock, reset and bus
    input wire        clk, rst_n, hsel, hwrite, hready,
    input wire [11:0] haddr,
    input wire [1:0]  htrans, lockLevel,
    input wire [31:0] hwdata, hrdata,
    // channel side
    input wire [7:0]  channelDirection,
    input wire [3:0]  compareRef, compareOut, captureStrobe,
    input wire        counterTickClock
);
    reg         dWr, dRd;
    reg  [11:0] dA;
    reg  [15:0] shEn, shDiv;
    reg  [1:0]  shCtl;
    wire        tk = hsel && hready && htrans == `TCP_HTRANS_NONSEQ;
    wire [15:0] keep = lockLevel[1] ? 16'h0888 : 16'h0000;
    // shadow of what software wrote
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dWr <= 1'b0;
            dRd <= 1'b0;
            dA <= 12'h000;
            shEn <= 16'h0000;
            shDiv <= 16'h0000;
            shCtl <= 2'h0;
        end else begin
            dWr <= tk && hwrite;
            dRd <= tk && !hwrite;
            dA <= haddr;
            if (dWr && dA == `TCP_ADDR_ENABLE)
                shEn <= (hwdata[15:0] & 16'h3FFF & ~keep) | (shEn & keep);
            if (dWr && dA == `TCP_ADDR_DIVIDER)
                shDiv <= hwdata[15:0];
            if (dWr && dA == `TCP_ADDR_CONTROL)
                shCtl <= hwdata[1:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_CH1_OUT: assert property ($past(channelDirection[1:0]) == 2'h0
        |-> compareOut[0] == ($past(shEn[0]) ?
        $past(compareRef[0] ^ shEn[1]) : $past(shEn[1])))
        else $error("channel 1 output wrong");
    AST_CH4_OUT: assert property ($past(channelDirection[7:6]) == 2'h0
        |-> compareOut[3] == ($past(shEn[12]) ?
        $past(compareRef[3] ^ shEn[13]) : $past(shEn[13])))
        else $error("channel 4 output wrong");
    AST_RD_ENABLE: assert property (dRd && dA == `TCP_ADDR_ENABLE
        |-> hrdata == {16'h0000, shEn}) else $error("enable readback wrong");
    AST_RD_DIVIDER: assert property (dRd && dA == `TCP_ADDR_DIVIDER
        |-> hrdata == {16'h0000, shDiv}) else $error("divider readback");
    AST_TICK_PERIOD: assert property (counterTickClock && shCtl[1]
        && shDiv == 16'h0003 |=> (!counterTickClock [*3] ##1 counterTickClock)
        or (##[0:3] !shCtl[1])) else $error("tick period wrong");
    AST_TICK_OFF: assert property ((!shCtl[1]) [*2] |-> !counterTickClock)
        else $error("tick while stopped");
    AST_CAP_EN: assert property (captureStrobe[0] |-> $past(shEn[0])
        && !($past(shEn[3]) && !$past(shEn[1])))
        else $error("capture while disabled");
    AST_CAP_DIR: assert property (captureStrobe[0]
        |-> $past(channelDirection[1:0]) != 2'h0)
        else $error("capture on output channel");
endmodule // tcp_timer_channels_asserts

bind tcp_timer_channels tcp_timer_channels_asserts uChk (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .hwrite(hwrite),
    .hready(hready), .haddr(haddr), .htrans(htrans),
    .lockLevel(lockLevel), .hwdata(hwdata), .hrdata(hrdata),
    .channelDirection(channelDirection), .compareRef(compareRef),
    .compareOut(compareOut), .captureStrobe(captureStrobe),
    .counterTickClock(counterTickClock));

// ==== testbench/tcp_timer_channels_tb.sv ====
// self-checking bench for the timer channel block
`timescale 1ns/1ns
`include "tcp_consts.vh"
module tcp_timer_channels_tb;
    reg         clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg         commutationEvent = 1'b0;
    reg  [11:0] haddr = 12'h000;
    reg  [1:0]  htrans = 2'h0, lockLevel = 2'h0;
    reg  [31:0] hwdata = 32'h0000_0000, rd;
    reg  [7:0]  channelDirection = 8'h00;
    reg  [3:0]  compareRef = 4'h0, channelInputPin = 4'h0;
    reg  [2:0]  compareRefComplement = 3'h0;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, counterTickClock;
    wire [3:0]  compareOut, captureStrobe;
    wire [2:0]  compareOutComplement;
    wire [15:0] capturedValue;
    integer     nErrors = 0, checked = 0, cyc = 0, nTick = 0, nCap = 0;
    integer     k, j, t0;
    always #10 clk = ~clk;
    tcp_timer_channels dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .channelDirection(channelDirection), .lockLevel(lockLevel),
        .commutationEvent(commutationEvent), .compareRef(compareRef),
        .compareRefComplement(compareRefComplement),
        .channelInputPin(channelInputPin), .compareOut(compareOut),
        .compareOutComplement(compareOutComplement),
        .captureStrobe(captureStrobe), .capturedValue(capturedValue),
        .counterTickClock(counterTickClock));
    task tallyAndFinish;
        $display("checks %0d errors %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (counterTickClock) nTick <= nTick + 1;
        if (captureStrobe[0]) nCap <= nCap + 1;
        if (cyc == 5000) begin
            nErrors = nErrors + 1;
            tallyAndFinish;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single ahb-lite transfer, then one idle cycle
    task bus(input w, input [11:0] a, input [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= `TCP_HTRANS_NONSEQ;
        @(posedge clk); while (!hreadyout) @(posedge clk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge clk); while (!hreadyout) @(posedge clk);
        rd = hrdata; hsel <= 1'b0;
        @(posedge clk);
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
        chk(hresp, 32'h0000_0000);
    endtask
    task regsTest;
        rdc(`TCP_ADDR_COUNTER, 32'h0000_0000);
        rdc(`TCP_ADDR_DIVIDER, 32'h0000_0000);
        for (k = 0; k < 4; k++) begin
            bus(1'b1, `TCP_ADDR_ENABLE, 32'hFFFF_FFFF);
            rdc(`TCP_ADDR_ENABLE, 32'h0000_3FFF);
            lockLevel <= k[1:0];
            bus(1'b1, `TCP_ADDR_ENABLE, 32'h0000_0000);
            rdc(`TCP_ADDR_ENABLE, k > 1 ? 32'h0000_0888 : 32'h0000_0000);
            lockLevel <= 2'h0;
        end
        bus(1'b1, `TCP_ADDR_COUNTER, 32'h0000_A5C3);
        rdc(`TCP_ADDR_COUNTER, 32'h0000_A5C3);
        rdc(12'h030, 32'h0000_0000);
    endtask
    task outTest;
        for (k = 0; k < 4; k++) for (j = 0; j < 2; j++) begin
            compareRef <= j ? 4'h6 : 4'h9;
            compareRefComplement <= j ? 3'h3 : 3'h4;
            bus(1'b1, `TCP_ADDR_ENABLE,
                {16'h0000, {4{k[1], k[0], k[1], k[0]}}});
            repeat (3) @(posedge clk);
            chk(compareOut, k[0] ? (j ? 4'h6 : 4'h9) ^ {4{k[1]}} : {4{k[1]}});
            chk(compareOutComplement, k[0] ? (j ? 3'h3 : 3'h4) ^ {3{k[1]}} : {3{k[1]}});
        end
    endtask
    task preloadTest;
        compareRefComplement <= 3'h0;
        bus(1'b1, `TCP_ADDR_ENABLE, 32'h0000_0005);
        bus(1'b1, `TCP_ADDR_CONTROL, 32'h0000_0001);
        bus(1'b1, `TCP_ADDR_ENABLE, 32'h0000_000D);
        repeat (3) @(posedge clk);
        chk(compareOutComplement[0], 32'h0000_0000);
        commutationEvent <= 1'b1;
        @(posedge clk);
        commutationEvent <= 1'b0;
        repeat (3) @(posedge clk);
        chk(compareOutComplement[0], 32'h0000_0001);
        bus(1'b1, `TCP_ADDR_CONTROL, 32'h0000_0000);
    endtask
    task tickTest;
        bus(1'b1, `TCP_ADDR_COUNTER, 32'h0000_0000);
        j = nTick;
        for (k = 0; k < 2; k++) begin
            bus(1'b1, `TCP_ADDR_DIVIDER, k * 3);
            bus(1'b1, `TCP_ADDR_CONTROL, 32'h0000_0002);
            repeat (4) @(posedge clk);
            t0 = nTick;
            repeat (40) @(posedge clk);
            chk(nTick - t0, k ? 10 : 40);
            bus(1'b1, `TCP_ADDR_CONTROL, 32'h0000_0000);
        end
        repeat (3) @(posedge clk);
        rdc(`TCP_ADDR_COUNTER, nTick - j);
    endtask
    // configurations and expected captures per rise and fall of the pin
    localparam [95:0] CFG = 96'h0001_000B_0009_0003_0001_0000;
    localparam [11:0] EXP = 12'b00_10_00_01_01_00;
    task capTest;
        bus(1'b1, `TCP_ADDR_CONTROL, 32'h0000_0000);
        bus(1'b1, `TCP_ADDR_COUNTER, 32'h0000_1234);
        for (k = 0; k < 6; k++) begin
            channelDirection <= k == 5 ? 8'h00 : 8'h01;
            bus(1'b1, `TCP_ADDR_ENABLE, CFG[k * 16 +: 16]);
            t0 = nCap;
            channelInputPin <= 4'h1;
            repeat (8) @(posedge clk);
            channelInputPin <= 4'h0;
            repeat (8) @(posedge clk);
            chk(nCap - t0, EXP[k * 2 +: 2]);
            if (k == 1) chk(capturedValue, 32'h0000_1234);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regsTest;
        outTest;
        preloadTest;
        tickTest;
        capTest;
        tallyAndFinish;
    end
endmodule // tcp_timer_channels_tb
